// file: inc/fel_pkg.sv
// Constants and shared types for the fault event logger
package fel_pkg;
  localparam int  DEPTH          = 21;
  localparam int  CLK_HZ         = 100_000_000;
  localparam int  TICK_S         = 1;
  localparam int  TICK_CYC       = CLK_HZ * TICK_S;
  localparam int  STAMP_W        = 32;
  localparam int  CODE_W         = 8;
  localparam int  NUM_W          = 16;
  localparam int  DIP_W          = 8;
  localparam int  FLASH_MS       = 500;
  localparam int  FLASH_CYC      = (CLK_HZ / 1000) * FLASH_MS;
  localparam logic [7:0] CODE_POWER_ON  = 8'h00;
  localparam logic [7:0] CODE_LOC_CLOSE = 8'hC8;
  localparam logic [7:0] CODE_LOC_OPEN  = 8'hC9;
  localparam logic [7:0] CODE_NET_CLOSE = 8'hCA;
  localparam logic [7:0] CODE_NET_OPEN  = 8'hCB;
  localparam logic [15:0] NUM_ONE       = 16'h0001;
  typedef enum logic [1:0] {FEL_OFF, FEL_GREEN, FEL_RED} fel_led_type;
endpackage

// file: rtl/fel_hours.sv
// Operating-hours counter with 1 s resolution
`timescale 1ns/1ns
module fel_hours #(
  parameter int TICK_CYC = fel_pkg::TICK_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         supply_ok,
  output logic [fel_pkg::STAMP_W-1:0]       seconds
);
  typedef struct packed {
    logic [31:0]                  div;
    logic [fel_pkg::STAMP_W-1:0]  sec;
  } fel_hours_type;
  fel_hours_type st_q;
  fel_hours_type st_d;

  always_comb
  begin
    st_d = st_q;
    if (supply_ok)
    begin
      if (st_q.div == 32'(TICK_CYC - 1))
      begin
        st_d.div = '0;
        st_d.sec = st_q.sec + 1'b1;
      end
      else
      begin
        st_d.div = st_q.div + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign seconds = st_q.sec;

  a_hours_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !supply_ok |=> $stable(seconds))
    else $error("hours advanced without supply");
endmodule // fel_hours

// file: rtl/fel_logger.sv
// Fault ring log, enable log, event memory and service state
`timescale 1ns/1ns
module fel_logger #(
  parameter int NFAULT   = 8,
  parameter int DEPTH    = fel_pkg::DEPTH,
  parameter int TICK_CYC = fel_pkg::TICK_CYC,
  parameter int FLASH_CYC = fel_pkg::FLASH_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         supply_ok,
  input  wire logic                         power_on,
  input  wire logic [NFAULT-1:0]            fault_in,
  input  wire logic [7:0]                   fault_code [NFAULT],
  input  wire logic                         loc_enable,
  input  wire logic                         net_enable,
  input  wire logic [fel_pkg::DIP_W-1:0]    dip_in,
  input  wire logic                         init_read,
  input  wire logic                         init_write,
  input  wire logic [4:0]                   rd_pos,
  output logic [fel_pkg::CODE_W-1:0]        rd_code,
  output logic [fel_pkg::NUM_W-1:0]         rd_num,
  output logic [fel_pkg::STAMP_W-1:0]       rd_stamp,
  output logic [4:0]                        log_count,
  output logic [fel_pkg::CODE_W-1:0]        en_code,
  output logic [fel_pkg::STAMP_W-1:0]       en_stamp,
  output logic [fel_pkg::DIP_W-1:0]         en_dip,
  output logic [fel_pkg::STAMP_W-1:0]       ev_close_stamp,
  output logic [fel_pkg::STAMP_W-1:0]       ev_open_stamp,
  output logic [fel_pkg::STAMP_W-1:0]       ev_read_stamp,
  output logic [fel_pkg::STAMP_W-1:0]       ev_write_stamp,
  input  wire logic                         motor_off,
  input  wire logic                         local_manual,
  input  wire logic                         pw_set,
  input  wire logic                         fw_start,
  input  wire logic                         fw_done,
  input  wire logic                         fw_abort,
  output logic                              fw_refused,
  output logic                              station_fail,
  output logic                              fw_run_new,
  output logic                              dev_ready,
  output logic                              led_bus,
  output logic                              led_fault,
  output fel_pkg::fel_led_type              led_device,
  input  wire logic                         factory_cmd,
  output logic                              param_reset,
  output logic                              factory_ok
);
  localparam int SW = fel_pkg::STAMP_W;
  localparam int CW = fel_pkg::CODE_W;
  localparam int NW = fel_pkg::NUM_W;

  typedef enum logic [1:0] {FEL_IDLE, FEL_LOAD, FEL_BROKEN} fel_fw_type;

  typedef struct packed {
    logic [DEPTH-1:0][CW-1:0]  code;
    logic [DEPTH-1:0][NW-1:0]  num;
    logic [DEPTH-1:0][SW-1:0]  stamp;
    logic [4:0]                cnt;
    logic [NFAULT-1:0]         flt;
    logic                      loc;
    logic                      net;
    logic                      pwr;
    logic [CW-1:0]             en_code;
    logic [SW-1:0]             en_stamp;
    logic [fel_pkg::DIP_W-1:0] en_dip;
    logic [SW-1:0]             ev_close;
    logic [SW-1:0]             ev_open;
    logic [SW-1:0]             ev_read;
    logic [SW-1:0]             ev_write;
    fel_fw_type                fw;
    logic                      refused;
    logic                      run_new;
    logic                      fac_ok;
    logic                      prst;
    logic [31:0]               flash;
    logic                      phase;
    logic [1:0][NFAULT-1:0]    fsync;
    logic [1:0][3:0]           psync;
    logic [CW-1:0]             rd_code;
    logic [NW-1:0]             rd_num;
    logic [SW-1:0]             rd_stamp;
  } fel_logger_type;

  fel_logger_type st_q;
  fel_logger_type st_d;

  logic [SW-1:0]              now;
  logic [NFAULT-1:0]          flt_s;
  logic                       loc_s;
  logic                       net_s;
  logic                       rd_s;
  logic                       wr_s;

  fel_hours #(
    .TICK_CYC (TICK_CYC)
  ) u_hours (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .supply_ok (supply_ok),
    .seconds   (now)
  );

  // Fault, enable and init pins pass two flops; only the second stage is read
  assign flt_s = st_q.fsync[1];
  assign {loc_s, net_s, rd_s, wr_s} = st_q.psync[1];

  logic [4:0] idx;
  assign idx = (rd_pos >= 5'h01 && rd_pos <= 5'(DEPTH)) ?
               rd_pos - 5'h01 : 5'h00;

  // Rises in one cycle are logged one an edge, lowest index first.
  // A fault that falls before its turn is lost, so levels must hold.
  logic [NFAULT-1:0] flt_rise;
  assign flt_rise = flt_s & ~st_q.flt;

  logic              push;
  logic [CW-1:0]     push_code;
  logic [NFAULT-1:0] push_sel;
  logic          pwr_rise;
  assign pwr_rise = power_on & ~st_q.pwr;

  always_comb
  begin
    push      = 1'b0;
    push_sel  = '0;
    push_code = fel_pkg::CODE_POWER_ON;
    for (int i = NFAULT - 1; i >= 0; i--)
    begin
      if (flt_rise[i])
      begin
        push      = 1'b1;
        push_code = fault_code[i];
        push_sel    = '0;
        push_sel[i] = 1'b1;
      end
    end
  end

  always_comb
  begin
    st_d     = st_q;
    st_d.fsync = {st_q.fsync[0], fault_in};
    st_d.psync = {st_q.psync[0],
                  {loc_enable, net_enable, init_read, init_write}};
    // Readout is registered: a new position shows one edge later
    st_d.rd_code  = st_q.code[idx];
    st_d.rd_num   = st_q.num[idx];
    st_d.rd_stamp = st_q.stamp[idx];
    // falling edge always tracked; unlogged rises stay pending
    st_d.flt = flt_s & ~(flt_rise & ~push_sel);
    st_d.loc = loc_s;
    st_d.net = net_s;
    // A power-on beaten by a fault rise waits for the next edge
    st_d.pwr = power_on & ~(pwr_rise & push);
    st_d.refused = 1'b0;
    st_d.fac_ok  = 1'b0;
    st_d.prst    = 1'b0;
    st_d.run_new = 1'b0;
    if (push || (pwr_rise && !(st_q.cnt != '0 &&
        st_q.code[0] == fel_pkg::CODE_POWER_ON)))
    begin
      for (int k = DEPTH - 1; k > 0; k--)
      begin
        st_d.code[k]  = st_q.code[k-1];
        st_d.num[k]   = st_q.num[k-1];
        st_d.stamp[k] = st_q.stamp[k-1];
      end
      st_d.code[0]  = push ? push_code : fel_pkg::CODE_POWER_ON;
      st_d.num[0]   = fel_pkg::NUM_ONE;
      st_d.stamp[0] = now;
      if (st_q.cnt != 5'(DEPTH))
        st_d.cnt = st_q.cnt + 1'b1;
    end
    else if (pwr_rise)
    begin
      st_d.num[0]   = st_q.num[0] + 1'b1;
    end
    if (loc_s != st_q.loc)
    begin
      st_d.en_code  = loc_s ? fel_pkg::CODE_LOC_CLOSE
                            : fel_pkg::CODE_LOC_OPEN;
      st_d.en_stamp = now;
      st_d.en_dip   = dip_in;
    end
    else if (net_s != st_q.net)
    begin
      st_d.en_code  = net_s ? fel_pkg::CODE_NET_CLOSE
                            : fel_pkg::CODE_NET_OPEN;
      st_d.en_stamp = now;
      st_d.en_dip   = dip_in;
    end
    if ((loc_s & ~st_q.loc) | (net_s & ~st_q.net))
      st_d.ev_close = now;
    if ((~loc_s & st_q.loc) | (~net_s & st_q.net))
      st_d.ev_open = now;
    if (rd_s)
      st_d.ev_read = now;
    if (wr_s)
      st_d.ev_write = now;
    unique case (st_q.fw)
      FEL_IDLE:
      begin
        if (fw_start)
        begin
          if (motor_off && local_manual && !pw_set)
            st_d.fw = FEL_LOAD;
          else
            st_d.refused = 1'b1;
        end
      end
      FEL_LOAD:
      begin
        if (fw_abort || !supply_ok)
          st_d.fw = FEL_BROKEN;
        else if (fw_done)
        begin
          st_d.fw      = FEL_IDLE;
          st_d.run_new = 1'b1;
        end
      end
      FEL_BROKEN:
      begin
        if (fw_start && motor_off && local_manual && !pw_set)
          st_d.fw = FEL_LOAD;
      end
    endcase
    if (st_q.fw != FEL_IDLE)
    begin
      if (st_q.flash == 32'(FLASH_CYC - 1))
      begin
        st_d.flash = '0;
        st_d.phase = ~st_q.phase;
      end
      else
        st_d.flash = st_q.flash + 1'b1;
    end
    if (factory_cmd && st_q.fw == FEL_IDLE)
      st_d.prst = 1'b1;
    if (st_q.prst)
      st_d.fac_ok = 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rd_code  = st_q.rd_code;
  assign rd_num   = st_q.rd_num;
  assign rd_stamp = st_q.rd_stamp;
  assign log_count      = st_q.cnt;
  assign en_code        = st_q.en_code;
  assign en_stamp       = st_q.en_stamp;
  assign en_dip         = st_q.en_dip;
  assign ev_close_stamp = st_q.ev_close;
  assign ev_open_stamp  = st_q.ev_open;
  assign ev_read_stamp  = st_q.ev_read;
  assign ev_write_stamp = st_q.ev_write;
  assign fw_refused     = st_q.refused;
  assign fw_run_new     = st_q.run_new;
  assign station_fail   = st_q.fw != FEL_IDLE;
  assign dev_ready      = st_q.fw == FEL_IDLE;
  assign led_bus        = station_fail & st_q.phase;
  assign led_fault      = station_fail & ~st_q.phase;
  assign led_device     = station_fail ? fel_pkg::FEL_RED
                                       : fel_pkg::FEL_GREEN;
  assign param_reset    = st_q.prst;
  assign factory_ok     = st_q.fac_ok;

  a_fault_push: assert property (@(posedge clk) disable iff (sys_rst)
    (|flt_rise) |=> st_q.stamp[0] == $past(now))
    else $error("fault rise not logged");
  a_fall_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (flt_rise == '0 && !pwr_rise) |=> $stable(st_q.cnt))
    else $error("entry written without rise");
  a_count_cap: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.cnt <= 5'(DEPTH))
    else $error("log count above depth");
  a_power_bump: assert property (@(posedge clk) disable iff (sys_rst)
    (pwr_rise && !push && st_q.cnt != '0 &&
     st_q.code[0] == fel_pkg::CODE_POWER_ON)
    |=> st_q.num[0] == $past(st_q.num[0]) + 1'b1)
    else $error("power-on not counted");
  a_shift_old: assert property (@(posedge clk) disable iff (sys_rst)
    (|flt_rise) |=> st_q.code[1] == $past(st_q.code[0]))
    else $error("ring did not shift");
  a_loc_code: assert property (@(posedge clk) disable iff (sys_rst)
    (loc_s && !st_q.loc) |=> en_code == fel_pkg::CODE_LOC_CLOSE)
    else $error("local close code wrong");
  a_fw_refuse: assert property (@(posedge clk) disable iff (sys_rst)
    (fw_start && st_q.fw == FEL_IDLE && pw_set)
    |=> fw_refused && !station_fail)
    else $error("update not refused");
  a_led_alt: assert property (@(posedge clk) disable iff (sys_rst)
    station_fail |-> (led_bus != led_fault) &&
    led_device == fel_pkg::FEL_RED && !dev_ready)
    else $error("update indication wrong");
  a_factory_ok: assert property (@(posedge clk) disable iff (sys_rst)
    param_reset |=> factory_ok)
    else $error("factory report missing");
endmodule // fel_logger

// file: sim/fault_event_logger_test.sv
// Self-checking bench for the fault event logger
`timescale 1ns/1ns
module fault_event_logger_test;
  logic                 clk, sys_rst, supply_ok, power_on;
  logic [7:0]           fault_in;
  logic [7:0]           fault_code [8];
  logic                 loc_enable, net_enable, init_read, init_write;
  logic [7:0]           dip_in, rd_code, en_code, en_dip;
  logic [4:0]           rd_pos, log_count;
  logic [15:0]          rd_num;
  logic [31:0]          rd_stamp, en_stamp, ev_close_stamp, ev_open_stamp;
  logic [31:0]          ev_read_stamp, ev_write_stamp;
  logic                 motor_off, local_manual, pw_set;
  logic                 fw_start, fw_done, fw_abort, factory_cmd;
  logic                 fw_refused, station_fail, fw_run_new, dev_ready;
  logic                 led_bus, led_fault, param_reset, factory_ok;
  fel_pkg::fel_led_type led_device;
  int                   mismatches;
  int                   tests_run;

  fel_logger #(.NFAULT(8), .TICK_CYC(10), .FLASH_CYC(4)) fel_logger_i (
    .clk, .sys_rst, .supply_ok, .power_on, .fault_in, .fault_code,
    .loc_enable, .net_enable, .dip_in, .init_read, .init_write, .rd_pos,
    .rd_code, .rd_num, .rd_stamp, .log_count, .en_code, .en_stamp, .en_dip,
    .ev_close_stamp, .ev_open_stamp, .ev_read_stamp, .ev_write_stamp,
    .motor_off, .local_manual, .pw_set, .fw_start, .fw_done, .fw_abort,
    .fw_refused, .station_fail, .fw_run_new, .dev_ready, .led_bus,
    .led_fault, .led_device, .factory_cmd, .param_reset, .factory_ok);

  fel_host_model fel_host_model_i (
    .clk, .fw_start, .fw_done, .fw_abort, .factory_cmd);

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run;
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Synced pins need three edges before the entry lands
  task automatic flt_pulse(input int i);
    @(negedge clk) fault_in[i] = 1'h1;
    repeat (4) @(negedge clk);
    fault_in[i] = 1'h0;
    repeat (4) @(negedge clk);
  endtask

  task automatic pwr;
    @(negedge clk) power_on = 1'h1;
    repeat (2) @(negedge clk);
    power_on = 1'h0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_power_fault;
    pwr();
    chk("count", 32'h1, 32'(log_count));
    chk("num", 32'h1, 32'(rd_num));
    pwr();
    chk("count", 32'h1, 32'(log_count));
    chk("num", 32'h2, 32'(rd_num));
    @(negedge clk) fault_in[2] = 1'h1;
    repeat (4) @(negedge clk);
    chk("count", 32'h2, 32'(log_count));
    chk("code", 32'h12, 32'(rd_code));
    fault_in[2] = 1'h0;
    repeat (4) @(negedge clk);
    chk("count", 32'h2, 32'(log_count));
    pwr();
    chk("num", 32'h1, 32'(rd_num));
    rd_pos = 5'h02;
    @(negedge clk) chk("pos2", 32'h12, 32'(rd_code));
    rd_pos = 5'h01;
  endtask

  // Stamps freeze without supply and resume with it
  task automatic t_stamp;
    logic [31:0] s0;
    logic [31:0] d;
    supply_ok = 1'h0;
    flt_pulse(0);
    s0 = rd_stamp;
    repeat (40) @(negedge clk);
    flt_pulse(1);
    chk("stamp_hold", s0, rd_stamp);
    supply_ok = 1'h1;
    repeat (35) @(negedge clk);
    flt_pulse(0);
    d = rd_stamp - s0;
    chk("stamp_step", 32'h1, 32'(d >= 3 && d <= 4));
  endtask

  task automatic t_fill;
    for (int e = 0; e < 22; e++)
      flt_pulse(e % 8);
    chk("count_full", 32'h15, 32'(log_count));
    for (int p = 1; p <= 21; p++)
    begin
      @(negedge clk) rd_pos = p[4:0];
      @(negedge clk);
      chk("fill_code", 32'h10 + 32'((22 - p) % 8), 32'(rd_code));
    end
    rd_pos = 5'h01;
  endtask

  // Two faults rising together both land, lower index first
  task automatic t_dual;
    @(negedge clk) fault_in[4:3] = 2'h3;
    repeat (5) @(negedge clk);
    chk("dual_count", 32'h15, 32'(log_count));
    chk("dual_new", 32'h14, 32'(rd_code));
    rd_pos = 5'h02;
    @(negedge clk) chk("dual_old", 32'h13, 32'(rd_code));
    fault_in[4:3] = 2'h0;
    rd_pos = 5'h01;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_enable;
    logic [7:0] codes [4] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB};
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk) dip_in = 8'h30 + 8'(k);
      if (k < 2)
        loc_enable = (k == 0);
      else
        net_enable = (k == 2);
      repeat (4) @(negedge clk);
      chk("en_code", 32'(codes[k]), 32'(en_code));
      chk("en_dip", 32'h30 + 32'(k), 32'(en_dip));
      chk("ev_stamp", en_stamp,
          (k % 2 == 0) ? ev_close_stamp : ev_open_stamp);
    end
    init_read = 1'h1;
    init_write = 1'h1;
    repeat (2) @(negedge clk);
    {init_read, init_write} = 2'h0;
    @(negedge clk);
    chk("ev_read", 32'h1, 32'(ev_read_stamp >= en_stamp));
    chk("ev_write", 32'h1, 32'(ev_write_stamp >= en_stamp));
  endtask

  task automatic t_fw_refuse;
    for (int c = 0; c < 3; c++)
    begin
      motor_off = (c != 0);
      local_manual = (c != 1);
      pw_set = (c == 2);
      fel_host_model_i.send(0, c + 1);
      chk("fw_refused", 32'h1, 32'(fw_refused));
      chk("station_fail", 32'h0, 32'(station_fail));
    end
    {motor_off, local_manual, pw_set} = 3'h6;
  endtask

  task automatic t_fw_update;
    int   tog;
    logic prev;
    fel_host_model_i.send(0, 1);
    chk("station_fail", 32'h1, 32'(station_fail));
    chk("led_device", 32'(fel_pkg::FEL_RED), 32'(led_device));
    tog = 0;
    prev = led_bus;
    repeat (12)
    begin
      @(negedge clk);
      chk("led_alt", 32'h1, 32'(led_bus !== led_fault));
      tog += (led_bus !== prev);
      prev = led_bus;
    end
    chk("led_flash", 32'h1, 32'(tog >= 2));
    fel_host_model_i.send(2, 1);
    repeat (3) @(negedge clk);
    chk("broken_fail", 32'h1, 32'(station_fail));
    chk("broken_ready", 32'h0, 32'(dev_ready));
    fel_host_model_i.send(0, 1);
    fel_host_model_i.send(1, 3);
    chk("fw_run_new", 32'h1, 32'(fw_run_new));
    chk("param_reset", 32'h0, 32'(param_reset));
    @(negedge clk) chk("station_fail", 32'h0, 32'(station_fail));
    chk("dev_ready", 32'h1, 32'(dev_ready));
  endtask

  task automatic t_factory;
    int k;
    fel_host_model_i.send(3, 1);
    chk("param_reset", 32'h1, 32'(param_reset));
    k = 0;
    while (factory_ok !== 1'h1 && k < 3)
    begin
      @(negedge clk);
      k++;
    end
    chk("factory_ok", 32'h1, 32'(factory_ok));
  endtask

  initial
  begin
    mismatches = 0;
    tests_run = 0;
    {sys_rst, supply_ok, power_on, fault_in} = 11'h600;
    {loc_enable, net_enable, init_read, init_write, dip_in} = 12'h0;
    {motor_off, local_manual, pw_set, rd_pos} = 8'hC1;
    for (int i = 0; i < 8; i++)
      fault_code[i] = 8'h10 + 8'(i);
    repeat (20) @(negedge clk);
    sys_rst = 1'h0;
    @(negedge clk);
    chk("reset_count", 32'h0, 32'(log_count));
    chk("reset_ready", 32'h1, 32'(dev_ready));
    t_power_fault();
    t_stamp();
    t_fill();
    t_dual();
    t_enable();
    t_fw_refuse();
    t_fw_update();
    t_factory();
    complete_run();
  end

  // About 460 cycles are needed; a hang runs far past that
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule // fault_event_logger_test

// file: sim/fel_host_model.sv
// Service host model that issues update and factory requests
`timescale 1ns/1ns
module fel_host_model (
  input  wire logic clk,
  output logic      fw_start,
  output logic      fw_done,
  output logic      fw_abort,
  output logic      factory_cmd
);
  initial
  begin
    fw_start    = 1'h0;
    fw_done     = 1'h0;
    fw_abort    = 1'h0;
    factory_cmd = 1'h0;
  end

  // Kind 0 start, 1 done, 2 abort, 3 factory; gap must be one or more,
  // so that a request never rises in the step where the last one fell
  task automatic send(input int kind, input int gap);
    repeat (gap) @(negedge clk);
    case (kind)
      0: fw_start = 1'h1;
      1: fw_done = 1'h1;
      2: fw_abort = 1'h1;
      default: factory_cmd = 1'h1;
    endcase
    @(negedge clk);
    {fw_start, fw_done, fw_abort, factory_cmd} = 4'h0;
  endtask
endmodule // fel_host_model
